// ===== src/red_pkg.sv
// Function
// - Compare amplitude against programmable 8-bit threshold
// - Mask detection for 26 ms after start
// - Clear writes zero flags; persisting errors stay
// - Signal error sets summary, held, signal flags
// - Disconnection raises the error interrupt request
// - VR mode: common level above half plus code/512
// - DC mode: level above half plus (code*8+1024)/4096
// - Cosine disconnection sets summary, held, cosine flags
// - Sine disconnection sets summary, held, sine flags
// - Conversion error raises the error interrupt request
// - Excess variation outside fixed high/low thresholds
// - Half period abnormal when excess exceeds half
// - Window abnormal share above half sets conversion flags
// - Tracking loop updates at 20 MHz
// - Synchronous detection of comparator bit forms variation
// - Sine/cosine tables fed back from angle accumulator
// - Amplitude low for 220 us flags signal error
// - Two-bit field selects window, 11b is 7.37 ms
// - Conversion error sets summary, held, conversion flags
package red_pkg;
	localparam int CLK_MHZ = 100;
	localparam int TRK_MHZ = 20;
	localparam int TRK_DIV = CLK_MHZ / TRK_MHZ;
	localparam int MASK_MS = 26;
	localparam int MASK_CYC = MASK_MS * 1000 * CLK_MHZ;
	localparam int AMP_US = 220;
	localparam int AMP_CYC = AMP_US * CLK_MHZ;
	localparam int DET_US0 = 920;
	localparam int DET_US1 = 1840;
	localparam int DET_US2 = 3680;
	localparam int DET_US3 = 7370;
	localparam logic [7:0] OFS_THR = 8'h00;
	localparam logic [7:0] OFS_CTL = 8'h04;
	localparam logic [7:0] OFS_SEL = 8'h08;
	localparam logic [7:0] OFS_FLG = 8'h0C;
	localparam int THR_AMP_LSB = 0;
	localparam int THR_VR_LSB = 8;
	localparam int THR_DC_LSB = 16;
	localparam int CTL_START = 0;
	localparam int CTL_CLR = 1;
	localparam int CTL_SENSOR_TYPE_SELECT = 2;
	localparam int CTL_INTERNAL_EXCITATION_SELECT = 3;
	localparam int CTL_DET_LSB = 4;
	localparam int CTL_LIVE = 8;
	localparam int FLG_DET_LSB = 4;
	localparam int FLG_ERR = 8;
	localparam int FLG_HELD = 9;
	localparam logic [7:0] THR_AMP_RST = 8'h1A;
	localparam logic [7:0] THR_VR_RST = 8'h29;
	localparam logic [7:0] THR_DC_RST = 8'h33;
	localparam logic [1:0] DET_RST = 2'h3;
	localparam logic [12:0] HALF_LVL = 13'h0800;
	localparam logic [12:0] DC_OFS = 13'h0400;
	localparam int LVL_SHIFT = 3;
	localparam logic signed [11:0] EPS_HI = 12'sh190;
	localparam logic signed [11:0] EPS_LO = 12'shE70;
	localparam logic [3:0] COS_OFS = 4'h4;
	localparam logic [7:0] SIN_LUT [16] = '{8'h00, 8'h31, 8'h5A, 8'h75, 8'h7F, 8'h75, 8'h5A,
		8'h31, 8'h00, 8'hCF, 8'hA6, 8'h8B, 8'h81, 8'h8B, 8'hA6, 8'hCF};
	typedef enum logic [1:0] {MASK_OFF, MASK_WAIT, MASK_LIVE} red_mask_t;
endpackage

// ===== src/red_cnv_chk.sv
`timescale 1ns/100ps
module red_cnv_chk #(
	parameter int HP_W = 16,
	parameter int WIN_W = 24,
	parameter int NHP_W = 12
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic enable,
	input wire logic excess,
	input wire logic exc_ref,
	input wire logic [WIN_W-1:0] win_cyc,
	output logic cnv_err
);
	logic ref_prev_r;
	logic [HP_W-1:0] hp_all_r;
	logic [HP_W-1:0] hp_hi_r;
	logic [WIN_W-1:0] win_r;
	logic [NHP_W-1:0] n_tot_r;
	logic [NHP_W-1:0] n_abn_r;
	logic cnv_err_r;
	logic hp_end;
	logic hp_bad;
	logic win_end;

	assign hp_end = exc_ref != ref_prev_r;
	assign hp_bad = {hp_hi_r, 1'b0} > {1'b0, hp_all_r};
	assign win_end = win_r >= win_cyc - 1'b1;
	assign cnv_err = cnv_err_r;

	always_ff @(posedge clk) begin
		if (!resetn)
			ref_prev_r <= 1'b0;
		else
			ref_prev_r <= exc_ref;
	end

	// Counters restart on each excitation edge
	always_ff @(posedge clk) begin
		if (!resetn || !enable || hp_end) begin
			hp_all_r <= '0;
			hp_hi_r <= '0;
		end else begin
			hp_all_r <= hp_all_r + 1'b1;
			hp_hi_r <= hp_hi_r + HP_W'(excess);
		end
	end

	// Verdict only at window end; a half period straddling it counts in the next window
	always_ff @(posedge clk) begin
		if (!resetn || !enable) begin
			win_r <= '0;
			n_tot_r <= '0;
			n_abn_r <= '0;
			cnv_err_r <= 1'b0;
		end else if (win_end) begin
			win_r <= '0;
			n_tot_r <= '0;
			n_abn_r <= '0;
			cnv_err_r <= {n_abn_r, 1'b0} > {1'b0, n_tot_r};
		end else begin
			win_r <= win_r + 1'b1;
			if (hp_end) begin
				n_tot_r <= n_tot_r + 1'b1;
				n_abn_r <= n_abn_r + NHP_W'(hp_bad);
			end
		end
	end
endmodule

// ===== src/red_top.sv
`timescale 1ns/100ps
module red_top #(
	parameter int MASK_CYC = red_pkg::MASK_CYC,
	parameter int AMP_CYC = red_pkg::AMP_CYC,
	parameter int DET_CYC0 = red_pkg::DET_US0 * red_pkg::CLK_MHZ,
	parameter int DET_CYC1 = red_pkg::DET_US1 * red_pkg::CLK_MHZ,
	parameter int DET_CYC2 = red_pkg::DET_US2 * red_pkg::CLK_MHZ,
	parameter int DET_CYC3 = red_pkg::DET_US3 * red_pkg::CLK_MHZ,
	parameter int CNT_W = 24
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [7:0] mon_amp_sin,
	input wire logic [7:0] mon_amp_cos,
	input wire logic [11:0] mon_lvl_sin,
	input wire logic [11:0] mon_lvl_cos,
	input wire logic cmp_bit,
	input wire logic exc_ref,
	output logic err_irq,
	output logic [7:0] sin_fb,
	output logic [7:0] cos_fb,
	output logic [15:0] angle
);
	logic [7:0] thr_amp_r;
	logic [7:0] thr_vr_r;
	logic [7:0] thr_dc_r;
	logic start_r;
	logic sensor_type_select_r;
	logic internal_excitation_select_r;
	logic [1:0] det_sel_r;
	logic [3:0] sel_r;
	logic [31:0] rdata_r;
	red_pkg::red_mask_t mask_r;
	logic [CNT_W-1:0] mask_cnt_r;
	logic [CNT_W-1:0] amp_cnt_r;
	logic sig_cond_r;
	logic cos_cond_r;
	logic sin_cond_r;
	logic [3:0] cat_r;
	logic [3:0] det_r;
	logic err_r;
	logic held_r;
	logic [2:0] trk_cnt_r;
	logic signed [11:0] eps_r;
	logic [15:0] phi_r;
	logic excess_r;
	logic [7:0] sin_fb_r;
	logic [7:0] cos_fb_r;
	logic live;
	logic clr;
	logic amp_low;
	logic chk_on;
	logic [12:0] vr_lim;
	logic [12:0] dc_lim;
	logic [12:0] lim;
	logic cnv_err;
	logic [3:0] cond;
	logic [3:0] set_main;
	logic [CNT_W-1:0] win_cyc;

	assign live = mask_r == red_pkg::MASK_LIVE;
	assign clr = wr && addr == red_pkg::OFS_CTL && wdata[red_pkg::CTL_CLR];
	assign rdata = rdata_r;
	assign err_irq = err_r;
	assign sin_fb = sin_fb_r;
	assign cos_fb = cos_fb_r;
	assign angle = phi_r;

	// Register writes
	always_ff @(posedge clk) begin
		if (!resetn) begin
			thr_amp_r <= red_pkg::THR_AMP_RST;
			thr_vr_r <= red_pkg::THR_VR_RST;
			thr_dc_r <= red_pkg::THR_DC_RST;
			start_r <= 1'b0;
			sensor_type_select_r <= 1'b0;
			internal_excitation_select_r <= 1'b0;
			det_sel_r <= red_pkg::DET_RST;
			sel_r <= 4'h0;
		end else if (wr) begin
			unique case (addr)
				red_pkg::OFS_THR: begin
					thr_amp_r <= wdata[red_pkg::THR_AMP_LSB +: 8];
					thr_vr_r <= wdata[red_pkg::THR_VR_LSB +: 8];
					thr_dc_r <= wdata[red_pkg::THR_DC_LSB +: 8];
				end
				red_pkg::OFS_CTL: begin
					start_r <= wdata[red_pkg::CTL_START];
					sensor_type_select_r <= wdata[red_pkg::CTL_SENSOR_TYPE_SELECT];
					internal_excitation_select_r <= wdata[red_pkg::CTL_INTERNAL_EXCITATION_SELECT];
					det_sel_r <= wdata[red_pkg::CTL_DET_LSB +: 2];
				end
				red_pkg::OFS_SEL: sel_r <= wdata[3:0];
				default: ;
			endcase
		end
	end

	// Read data stand one cycle, zero otherwise and for unmapped offsets
	always_ff @(posedge clk) begin
		if (!resetn || !rd) begin
			rdata_r <= 32'h0;
		end else begin
			unique case (addr)
				red_pkg::OFS_THR: rdata_r <= {8'h00, thr_dc_r, thr_vr_r, thr_amp_r};
				red_pkg::OFS_CTL: rdata_r <= {23'h0, live, 2'h0, det_sel_r, internal_excitation_select_r, sensor_type_select_r,
					1'b0, start_r};
				red_pkg::OFS_SEL: rdata_r <= {28'h0, sel_r};
				red_pkg::OFS_FLG: rdata_r <= {22'h0, held_r, err_r, det_r, cat_r};
				default: rdata_r <= 32'h0;
			endcase
		end
	end

	// Start mask: error flags stay quiet while the front end settles
	always_ff @(posedge clk) begin
		if (!resetn || !start_r) begin
			mask_r <= red_pkg::MASK_OFF;
			mask_cnt_r <= '0;
		end else begin
			unique case (mask_r)
				red_pkg::MASK_OFF: mask_r <= red_pkg::MASK_WAIT;
				red_pkg::MASK_WAIT: begin
					mask_cnt_r <= mask_cnt_r + 1'b1;
					if (mask_cnt_r == CNT_W'(MASK_CYC - 1))
						mask_r <= red_pkg::MASK_LIVE;
				end
				red_pkg::MASK_LIVE: ;
			endcase
		end
	end

	// Amplitude loss needs both monitors low for the whole persistence time
	assign amp_low = mon_amp_sin < thr_amp_r && mon_amp_cos < thr_amp_r;

	always_ff @(posedge clk) begin
		if (!resetn || !amp_low) begin
			amp_cnt_r <= '0;
			sig_cond_r <= 1'b0;
		end else begin
			if (amp_cnt_r != CNT_W'(AMP_CYC))
				amp_cnt_r <= amp_cnt_r + 1'b1;
			sig_cond_r <= amp_cnt_r >= CNT_W'(AMP_CYC - 1);
		end
	end

	// Levels are in steps of supply/4096, so code/512 is code times 8
	assign vr_lim = red_pkg::HALF_LVL + (13'(thr_vr_r) << red_pkg::LVL_SHIFT);
	assign dc_lim = red_pkg::HALF_LVL + red_pkg::DC_OFS
		+ (13'(thr_dc_r) << red_pkg::LVL_SHIFT);
	assign lim = sensor_type_select_r ? vr_lim : dc_lim;
	// External excitation with a non-VR sensor has no disconnection check
	assign chk_on = sensor_type_select_r || internal_excitation_select_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cos_cond_r <= 1'b0;
			sin_cond_r <= 1'b0;
		end else begin
			cos_cond_r <= chk_on && {1'b0, mon_lvl_cos} > lim;
			sin_cond_r <= chk_on && {1'b0, mon_lvl_sin} > lim;
		end
	end

	// Tracking loop
	always_ff @(posedge clk) begin
		if (!resetn || trk_cnt_r == 3'(red_pkg::TRK_DIV - 1))
			trk_cnt_r <= 3'h0;
		else
			trk_cnt_r <= trk_cnt_r + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			eps_r <= 12'sh000;
			phi_r <= 16'h0000;
		end else if (trk_cnt_r == 3'h0) begin
			// Comparator sign flipped by excitation phase strips the carrier
			eps_r <= (cmp_bit ^ exc_ref) ? eps_r - 12'sh001 : eps_r + 12'sh001;
			phi_r <= phi_r + {{4{eps_r[11]}}, eps_r};
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sin_fb_r <= 8'h00;
			cos_fb_r <= 8'h00;
			excess_r <= 1'b0;
		end else begin
			sin_fb_r <= red_pkg::SIN_LUT[phi_r[15:12]];
			cos_fb_r <= red_pkg::SIN_LUT[phi_r[15:12] + red_pkg::COS_OFS];
			excess_r <= eps_r > red_pkg::EPS_HI || eps_r < red_pkg::EPS_LO;
		end
	end

	always_comb begin
		unique case (det_sel_r)
			2'h0: win_cyc = CNT_W'(DET_CYC0);
			2'h1: win_cyc = CNT_W'(DET_CYC1);
			2'h2: win_cyc = CNT_W'(DET_CYC2);
			2'h3: win_cyc = CNT_W'(DET_CYC3);
		endcase
	end

	red_cnv_chk #(
		.WIN_W(CNT_W)
	) u_cnv (
		.clk(clk),
		.resetn(resetn),
		.enable(live),
		.excess(excess_r),
		.exc_ref(exc_ref),
		.win_cyc(win_cyc),
		.cnv_err(cnv_err)
	);

	// Flags
	assign cond = {cnv_err, sin_cond_r, cos_cond_r, sig_cond_r} & {4{live}};
	assign set_main = cond & ~sel_r;

	// Set beats clear so a persisting error survives the clear write
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cat_r <= 4'h0;
			det_r <= 4'h0;
			err_r <= 1'b0;
			held_r <= 1'b0;
		end else begin
			cat_r <= (clr ? 4'h0 : cat_r) | set_main;
			det_r <= (clr ? 4'h0 : det_r) | cond;
			err_r <= (clr ? 1'b0 : err_r) | (|set_main);
			held_r <= (clr ? 1'b0 : held_r) | (|set_main);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_CLR_PERSIST: assert property (
		clr && cond[0] |=> det_r[0] && cat_r[0] == !sel_r[0] && (err_r || sel_r[0]))
		else $error("persisting signal error lost on clear");
	AST_CLR_WORKS: assert property (
		clr && cond == 4'h0 |=> cat_r == 4'h0 && det_r == 4'h0 && !err_r)
		else $error("clear left flags set");
	AST_MASK_TIME: assert property (
		$rose(live) |-> $past(mask_cnt_r) == CNT_W'(MASK_CYC - 1) && $past(start_r))
		else $error("mask released at wrong time");
	AST_MASK_QUIET: assert property (
		!live && !clr ##1 !live |-> $stable(det_r))
		else $error("flag set while masked");
	AST_SIG_SET: assert property (
		cond[0] && !sel_r[0] |=> err_r && held_r && cat_r[0] && det_r[0])
		else $error("signal error flags not set");
	AST_COS_SET: assert property (
		cond[1] && !sel_r[1] |=> err_r && held_r && cat_r[1] && det_r[1])
		else $error("cosine disconnect flags not set");
	AST_SIN_SET: assert property (
		cond[2] && !sel_r[2] |=> err_r && held_r && cat_r[2] && det_r[2])
		else $error("sine disconnect flags not set");
	AST_CNV_SET: assert property (
		cond[3] && !sel_r[3] |=> err_irq && held_r && cat_r[3] && det_r[3])
		else $error("conversion error flags not set");
	AST_DISC_IRQ: assert property (
		live && (cos_cond_r && !sel_r[1] || sin_cond_r && !sel_r[2]) |=> err_irq)
		else $error("disconnect did not raise request");
	AST_AMP_TIME: assert property (
		$rose(sig_cond_r) |-> $past(amp_low) && $past(amp_cnt_r) == CNT_W'(AMP_CYC - 1))
		else $error("signal error persistence wrong");
	AST_VR_LIM: assert property (
		sensor_type_select_r && mon_lvl_cos > 12'(vr_lim) && !vr_lim[12] && $stable(sensor_type_select_r) |=> cos_cond_r)
		else $error("VR disconnect missed");
	AST_EXCESS: assert property (
		eps_r > red_pkg::EPS_HI |=> excess_r)
		else $error("excess variation missed");

	COV_SIG: cover property (live && cond[0] ##1 err_irq);
	COV_CNV: cover property (live && $rose(cnv_err));
	COV_CLR_HOLD: cover property (clr && cond[1]);
endmodule

// ===== bench/red_sensor_type_select.sv
`timescale 1ns/100ps
module red_sensor_type_select (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [2:0] fault,
	input wire logic [11:0] lvl,
	output logic [7:0] amp_s,
	output logic [7:0] amp_c,
	output logic [11:0] lvl_s,
	output logic [11:0] lvl_c,
	output logic cmp_bit,
	output logic exc_ref
);
	logic [5:0] hcnt_r;
	logic ref_nxt;
	assign ref_nxt = (hcnt_r == 6'h27) ? ~exc_ref : exc_ref;
	// Half period of 40 cycles; 1 = both amplitudes lost, 2/3 = sin/cos level, 4 = loop stuck
	always_ff @(posedge clk) begin
		if (!resetn) begin
			hcnt_r <= 6'h00;
			exc_ref <= 1'b0;
			cmp_bit <= 1'b0;
		end else begin
			hcnt_r <= (hcnt_r == 6'h27) ? 6'h00 : hcnt_r + 6'h01;
			exc_ref <= ref_nxt;
			// Alternating bit keeps the integrator centred while healthy
			// Stuck loop: bit follows the phase, so the detector sees one sign and drifts
			cmp_bit <= (fault == 3'h4) ? ref_nxt : ~cmp_bit;
		end
	end
	assign amp_s = (fault == 3'h1) ? 8'h05 : 8'h60;
	assign amp_c = (fault == 3'h1) ? 8'h05 : 8'h60;
	assign lvl_s = (fault == 3'h2) ? lvl : 12'h800;
	assign lvl_c = (fault == 3'h3) ? lvl : 12'h800;
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	localparam int MASK = 50;
	localparam int AMP = 20;
	logic clk, resetn, wr, rd, err_irq, cmp_bit, exc_ref;
	logic [7:0] addr, amp_s, amp_c, sin_fb, cos_fb, vr, dc;
	logic [31:0] wdata, rdata, rv;
	logic [11:0] lvl_s, lvl_c, lvl;
	logic [15:0] angle;
	logic [2:0] fault;
	int err_total, samples_checked, cyc, n, tc, lim, ctl, ef;
	// Case code: fault, sensor type, internal excitation, select, level above limit
	int cases [7] = '{'h10010, 'h21000, 'h21001, 'h31001, 'h20101, 'h30121, 'h20001};
	red_top #(.MASK_CYC(MASK), .AMP_CYC(AMP), .DET_CYC0(200), .DET_CYC1(300), .DET_CYC2(400),
		.DET_CYC3(800)) DUT (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .mon_amp_sin(amp_s), .mon_amp_cos(amp_c),
		.mon_lvl_sin(lvl_s), .mon_lvl_cos(lvl_c), .cmp_bit(cmp_bit), .exc_ref(exc_ref),
		.err_irq(err_irq), .sin_fb(sin_fb), .cos_fb(cos_fb), .angle(angle));
	red_sensor_type_select sensor_type_select (.clk(clk), .resetn(resetn), .fault(fault), .lvl(lvl), .amp_s(amp_s),
		.amp_c(amp_c), .lvl_s(lvl_s), .lvl_c(lvl_c), .cmp_bit(cmp_bit), .exc_ref(exc_ref));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task final_report;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 100000) begin
			err_total++;
			final_report;
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		// Read data stand until this edge; the flop updates only after it
		@(posedge clk);
		rv = rdata;
		chk(rv, exp);
	endtask
	task wait_irq(input int lim_c);
		n = 0;
		while (err_irq !== 1'b1 && n < lim_c) begin
			@(posedge clk);
			n++;
		end
	endtask
	// Bench model of the flag register: category index, select bit, sticky summary
	function automatic int exp_flg(int f, int sel, bit hit);
		int idx;
		idx = (f == 1) ? 0 : (f == 2) ? 2 : (f == 3) ? 1 : 3;
		if (!hit) return 0;
		if (sel[idx]) return 1 << (idx + 4);
		return 'h300 | (1 << idx) | (1 << (idx + 4));
	endfunction
	// Sixteen-step sine of amplitude 127, signed
	function automatic logic [7:0] exp_sin(int k);
		return 8'(int'(127.0 * $sin(6.2831853 * k / 16.0)));
	endfunction
	task chk_fb;
		logic [15:0] a;
		@(posedge clk);
		a = angle;
		@(posedge clk);
		chk({sin_fb, cos_fb}, {exp_sin(a[15:12]), exp_sin(a[15:12] + 4)});
	endtask
	initial begin
		{resetn, wr, rd, addr, wdata, fault, lvl} = '0;
		void'($urandom(50171));
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		chk({sin_fb, cos_fb, angle}, 32'h0);
		rdchk(8'h00, 32'h0033291A);
		rdchk(8'h04, 32'h30);
		rdchk(8'h08, 32'h0);
		rdchk(8'h10, 32'h0);
		vr = 8'($urandom_range(255));
		// Codes from 128 up put the DC limit beyond full scale of the level input
		dc = 8'($urandom_range(127));
		wr_reg(8'h10, 32'hFFFFFFFF);
		wr_reg(8'h00, {8'h00, dc, vr, 8'h1A});
		rdchk(8'h00, {8'h00, dc, vr, 8'h1A});
		$display("test registers done");
		fault <= 3'h1;
		wr_reg(8'h04, 32'h31);
		repeat (MASK - 8) @(posedge clk);
		rdchk(8'h0C, 32'h0);
		rdchk(8'h04, 32'h31);
		repeat (10) @(posedge clk);
		rdchk(8'h04, 32'h131);
		wait_irq(AMP + 10);
		rdchk(8'h0C, exp_flg(1, 0, 1));
		wr_reg(8'h04, 32'h33);
		rdchk(8'h0C, exp_flg(1, 0, 1));
		fault <= 3'h0;
		repeat (3) @(posedge clk);
		rdchk(8'h0C, exp_flg(1, 0, 1));
		wr_reg(8'h04, 32'h33);
		rdchk(8'h0C, 32'h0);
		rdchk(8'h04, 32'h131);
		fault <= 3'h1;
		wait_irq(AMP + 10);
		chk(32'(n >= AMP && n <= AMP + 4), 32'h1);
		fault <= 3'h0;
		wr_reg(8'h04, 32'h33);
		$display("test signal loss done");
		for (int i = 0; i < 7; i++) begin
			tc = cases[i];
			ctl = 'h31 | (((tc >> 12) & 1) << 2) | (((tc >> 8) & 1) << 3);
			lim = ((tc >> 12) & 1) ? 2048 + vr * 8 : 3072 + dc * 8;
			lvl <= 12'(lim + (tc & 1));
			ef = exp_flg(tc >> 16, (tc >> 4) & 'hF, (tc >> 16) == 1 || ((tc & 1) && (ctl & 'hC)));
			wr_reg(8'h08, (tc >> 4) & 'hF);
			wr_reg(8'h04, ctl);
			fault <= 3'(tc >> 16);
			repeat (AMP + 10) @(posedge clk);
			rdchk(8'h0C, ef);
			chk(32'(err_irq), 32'((ef >> 8) & 1));
			fault <= 3'h0;
			repeat (3) @(posedge clk);
			wr_reg(8'h04, ctl | 2);
			rdchk(8'h0C, 32'h0);
		end
		$display("test disconnect done");
		wr_reg(8'h08, 32'h0);
		wr_reg(8'h04, 32'h01);
		rdchk(8'h0C, 32'h0);
		fault <= 3'h4;
		wait_irq(20000);
		rdchk(8'h0C, exp_flg(4, 0, 1));
		chk(32'(err_irq), 32'h1);
		repeat (4) chk_fb;
		$display("test conversion done");
		final_report;
	end
endmodule
